/* design/dpo_dio_top.sv */
// Local design decisions: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
// Operation
// - Thirty-two digital bits in four 8-bit ports, port 0 lowest.
// - Direction is chosen per 8-bit port, never per bit.
// - Every analog converter has its own independent overload monitor.
// - Open, unwired, miswired sense or short output raises that flag.
// - Missing two-wire sense jumpers flag only that channel.
// - Overload flags read on port 4, bit n for converter n.
// - Writing one to a port 4 bit clears that sticky flag.
module dpo_dio_top #(
  parameter int unsigned NumPorts = dpo_pkg::PortCount,
  parameter int unsigned NumConv  = dpo_pkg::ConvCount
) (
  input  wire logic                  clock,     // 200 MHz system clock.
  input  wire logic                  rst,       // Synchronous reset.
  input  wire logic                  awvalid,   // Write address valid.
  output logic                       awready,   // Write address ready.
  input  wire logic [7:0]            awaddr,    // Write byte address.
  input  wire logic                  wvalid,    // Write data valid.
  output logic                       wready,    // Write data ready.
  input  wire logic [31:0]           wdata,     // Write data.
  input  wire logic [3:0]            wstrb,     // Write byte strobes.
  output logic                       bvalid,    // Write response valid.
  input  wire logic                  bready,    // Write response ready.
  output logic [1:0]                 bresp,     // Write response code.
  input  wire logic                  arvalid,   // Read address valid.
  output logic                       arready,   // Read address ready.
  input  wire logic [7:0]            araddr,    // Read byte address.
  output logic                       rvalid,    // Read data valid.
  input  wire logic                  rready,    // Read data ready.
  output logic [31:0]                rdata,     // Read data.
  output logic [1:0]                 rresp,     // Read response code.
  input  wire logic [31:0]           dioIn,     // Connector pin levels.
  output logic      [31:0]           dioOut,    // Connector pin drive.
  output logic      [31:0]           dioOe,     // Pin output enables.
  input  wire logic [NumConv-1:0]    ovlSense,  // Converter monitor faults.
  output logic                       irq        // Overload interrupt.
);

  typedef struct packed {
    logic [31:0]          inSync1;
    logic [31:0]          inSync2;
    logic [31:0]          outData;
    logic [NumPorts-1:0]  portDir;
    logic [NumConv-1:0]   irqMask;
    dpo_pkg::dpo_wr_e     wrState;
    logic                 awHeld;
    logic [7:0]           awAddr;
    logic                 wHeld;
    logic [31:0]          wData;
    logic [3:0]           wStrb;
    logic [1:0]           bResp;
    dpo_pkg::dpo_rd_e     rdState;
    logic [31:0]          rData;
    logic [1:0]           rResp;
    logic                 irqOut;
  } dpo_top_state_s;

  dpo_top_state_s     state_q;
  dpo_top_state_s     state_d;
  logic [NumConv-1:0] ovlFlags;
  logic [NumConv-1:0] ovlClear;
  logic               wrFire;
  logic [7:0]         wrAddrCur;
  logic [31:0]        wrDataCur;
  logic [3:0]         wrStrbCur;

  // Merges strobed bytes of new data over old data.
  function automatic logic [31:0] strobeMerge(
    input logic [31:0] oldVal,
    input logic [31:0] newVal,
    input logic [3:0]  strb
  );
    logic [31:0] res;
    res = oldVal;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = newVal[b*8 +: 8];
      end
    end
    return res;
  endfunction : strobeMerge

  // Expands one direction bit per port into one enable per pin.
  function automatic logic [31:0] portExpand(
    input logic [NumPorts-1:0] dir
  );
    logic [31:0] res;
    res = dpo_pkg::ResetZero;
    for (int p = 0; p < NumPorts; p++) begin
      res[p*dpo_pkg::PortWidth +: dpo_pkg::PortWidth] = {8{dir[p]}};
    end
    return res;
  endfunction : portExpand

  // A held item stands in for the bus, so either order completes a write.
  assign wrAddrCur = state_q.awHeld ? state_q.awAddr : awaddr;
  assign wrDataCur = state_q.wHeld ? state_q.wData : wdata;
  assign wrStrbCur = state_q.wHeld ? state_q.wStrb : wstrb;
  assign wrFire    = (state_q.wrState == dpo_pkg::WrIdle)
                     && (state_q.awHeld || awvalid)
                     && (state_q.wHeld || wvalid);
  // A zero written to a flag bit leaves it untouched.
  assign ovlClear  = (wrFire && wrAddrCur == dpo_pkg::OffOvlStat
                      && wrStrbCur[0])
                     ? wrDataCur[NumConv-1:0] : '0;

  dpo_overload_flags #(
    .NumConv (NumConv)
  ) u_flags (
    .clock    (clock),
    .rst      (rst),
    .faultPin (ovlSense),
    .clearOne (ovlClear),
    .flags    (ovlFlags)
  );

  always_comb begin
    state_d         = state_q;
    state_d.inSync1 = dioIn;
    state_d.inSync2 = state_q.inSync1;
    state_d.irqOut  = |(ovlFlags & state_q.irqMask);

    // Write channel: address and data taken in either order.
    case (state_q.wrState)
      dpo_pkg::WrIdle: begin
        if (awvalid && !state_q.awHeld) begin
          state_d.awHeld = 1'b1;
          state_d.awAddr = awaddr;
        end
        if (wvalid && !state_q.wHeld) begin
          state_d.wHeld = 1'b1;
          state_d.wData = wdata;
          state_d.wStrb = wstrb;
        end
        if (wrFire) begin
          state_d.awHeld  = 1'b0;
          state_d.wHeld   = 1'b0;
          state_d.wrState = dpo_pkg::WrResp;
          state_d.bResp   = dpo_pkg::RespOkay;
          case (wrAddrCur)
            dpo_pkg::OffDioOut: begin
              state_d.outData = strobeMerge(state_q.outData, wrDataCur,
                                            wrStrbCur);
            end
            dpo_pkg::OffDir: begin
              if (wrStrbCur[0]) begin
                state_d.portDir = wrDataCur[NumPorts-1:0];
              end
            end
            dpo_pkg::OffIrqMask: begin
              if (wrStrbCur[0]) begin
                state_d.irqMask = wrDataCur[NumConv-1:0];
              end
            end
            dpo_pkg::OffOvlStat, dpo_pkg::OffDioIn: begin
            end
            default: begin
              state_d.bResp = dpo_pkg::RespSlvErr;
            end
          endcase
        end
      end
      dpo_pkg::WrResp: begin
        if (bready) begin
          state_d.wrState = dpo_pkg::WrIdle;
        end
      end
      default: begin
        state_d.wrState = dpo_pkg::WrIdle;
      end
    endcase

    case (state_q.rdState)
      dpo_pkg::RdIdle: begin
        if (arvalid) begin
          state_d.rdState = dpo_pkg::RdResp;
          state_d.rResp   = dpo_pkg::RespOkay;
          state_d.rData   = dpo_pkg::ResetZero;
          case (araddr)
            dpo_pkg::OffDioOut:  state_d.rData = state_q.outData;
            // Output ports read back their driven value, inputs the pins.
            dpo_pkg::OffDioIn:   state_d.rData =
              (state_q.inSync2 & ~portExpand(state_q.portDir))
              | (state_q.outData & portExpand(state_q.portDir));
            dpo_pkg::OffDir:
              state_d.rData[NumPorts-1:0] = state_q.portDir;
            dpo_pkg::OffOvlStat:
              state_d.rData[NumConv-1:0] = ovlFlags;
            dpo_pkg::OffIrqMask:
              state_d.rData[NumConv-1:0] = state_q.irqMask;
            default: state_d.rResp = dpo_pkg::RespSlvErr;
          endcase
        end
      end
      dpo_pkg::RdResp: begin
        if (rready) begin
          state_d.rdState = dpo_pkg::RdIdle;
        end
      end
      default: begin
        state_d.rdState = dpo_pkg::RdIdle;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state_q         <= '0;
      state_q.portDir <= dpo_pkg::DirResetAll;
      state_q.wrState <= dpo_pkg::WrIdle;
      state_q.rdState <= dpo_pkg::RdIdle;
    end else begin
      state_q <= state_d;
    end
  end

  assign awready = (state_q.wrState == dpo_pkg::WrIdle) && !state_q.awHeld;
  assign wready  = (state_q.wrState == dpo_pkg::WrIdle) && !state_q.wHeld;
  assign bvalid  = (state_q.wrState == dpo_pkg::WrResp);
  assign bresp   = state_q.bResp;
  assign arready = (state_q.rdState == dpo_pkg::RdIdle);
  assign rvalid  = (state_q.rdState == dpo_pkg::RdResp);
  assign rdata   = state_q.rData;
  assign rresp   = state_q.rResp;
  assign dioOut  = state_q.outData;
  assign dioOe   = portExpand(state_q.portDir);
  assign irq     = state_q.irqOut;

  port_uniform_a: assert property (@(posedge clock) disable iff (rst)
    dioOe[7:0] == {8{dioOe[0]}} && dioOe[15:8] == {8{dioOe[8]}}
    && dioOe[23:16] == {8{dioOe[16]}} && dioOe[31:24] == {8{dioOe[24]}})
    else $error("Port direction differs inside a port.");

  reset_inputs_a: assert property (@(posedge clock)
    $fell(rst) |-> dioOe == 32'h0000_0000)
    else $error("Ports not inputs after reset.");

  // Reset must also drop a pending answer, or a master takes a stale one.
  reset_outputs_a: assert property (@(posedge clock)
    rst |=> dioOe == 32'h0000_0000 && !irq && !bvalid && !rvalid)
    else $error("Outputs not cleared by reset.");

  dir_write_a: assert property (@(posedge clock) disable iff (rst)
    wrFire && wrAddrCur == dpo_pkg::OffDir && wrStrbCur[0]
    |=> dioOe[15:8] == {8{$past(wrDataCur[1])}})
    else $error("Port 1 direction not taken from write.");

  out_write_a: assert property (@(posedge clock) disable iff (rst)
    wrFire && wrAddrCur == dpo_pkg::OffDioOut && wrStrbCur == 4'hF
    |=> dioOut == $past(wrDataCur))
    else $error("Output data not taken from write.");

  // The pin image is read only; a write there must not reach the outputs.
  ro_write_a: assert property (@(posedge clock) disable iff (rst)
    wrFire && wrAddrCur == dpo_pkg::OffDioIn |=> $stable(dioOut))
    else $error("Write to pin image changed output data.");

  zero_keeps_a: assert property (@(posedge clock) disable iff (rst)
    ovlFlags[2] && !ovlClear[2] |=> ovlFlags[2])
    else $error("Flag lost on write of zero.");

  clear_works_a: assert property (@(posedge clock) disable iff (rst)
    ovlClear[5] && !u_flags.state_q.sync2[5] |=> !ovlFlags[5])
    else $error("Write of one did not clear flag.");

  status_read_a: assert property (@(posedge clock) disable iff (rst)
    arready && arvalid && araddr == dpo_pkg::OffOvlStat
    |=> rvalid && rdata[7:0] == $past(ovlFlags))
    else $error("Status read does not show flags.");

  ovl_chain_a: assert property (@(posedge clock) disable iff (rst)
    ovlSense[7] |-> ##3 ovlFlags[7])
    else $error("Converter fault not flagged within three cycles.");

  chan_isolated_a: assert property (@(posedge clock)
    disable iff (rst)
    !ovlFlags[1] && !u_flags.state_q.sync2[1] |=> !ovlFlags[1])
    else $error("Flag set without its own channel fault.");

  // The interrupt is registered and trails the unmasked flags by one cycle.
  irq_level_a: assert property (@(posedge clock) disable iff (rst)
    |(ovlFlags & state_q.irqMask) |=> irq)
    else $error("Interrupt missing for unmasked flag.");

  irq_drop_a: assert property (@(posedge clock) disable iff (rst)
    !(|(ovlFlags & state_q.irqMask)) |=> !irq)
    else $error("Interrupt high with no unmasked flag.");

  mask_write_a: assert property (@(posedge clock) disable iff (rst)
    wrFire && wrAddrCur == dpo_pkg::OffIrqMask && wrStrbCur[0]
    |=> state_q.irqMask[0] == $past(wrDataCur[0]))
    else $error("Interrupt mask not taken from write.");

  // The master may stall the answer; it must not change while it waits.
  bresp_hold_a: assert property (@(posedge clock) disable iff (rst)
    bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("Write response dropped before it was taken.");

  rdata_hold_a: assert property (@(posedge clock) disable iff (rst)
    rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("Read data dropped before it was taken.");

endmodule : dpo_dio_top

/* design/dpo_overload_flags.sv */
`timescale 1ns/1ps
// Per-converter sticky overload flags with write-one-to-clear.
module dpo_overload_flags #(
  parameter int unsigned NumConv = dpo_pkg::ConvCount
) (
  input  wire logic               clock,    // System clock.
  input  wire logic               rst,      // Synchronous reset.
  input  wire logic [NumConv-1:0] faultPin, // Raw monitor outputs.
  input  wire logic [NumConv-1:0] clearOne, // Write-one-to-clear mask.
  output logic      [NumConv-1:0] flags     // Sticky flags.
);

  typedef struct packed {
    logic [NumConv-1:0] sync1;
    logic [NumConv-1:0] sync2;
    logic [NumConv-1:0] flag;
  } dpo_flag_state_s;

  dpo_flag_state_s state_q;
  dpo_flag_state_s state_d;

  always_comb begin
    state_d       = state_q;
    state_d.sync1 = faultPin;
    state_d.sync2 = state_q.sync1;
    // Each channel is independent; a new fault beats a clear in the same cycle.
    state_d.flag  = (state_q.flag & ~clearOne) | state_q.sync2;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign flags = state_q.flag;

  flag_sticks_a: assert property (@(posedge clock) disable iff (rst)
    state_q.flag[0] && !clearOne[0] |=> state_q.flag[0])
    else $error("Overload flag dropped without a clear.");

  // Two synchroniser stages and the flag itself put the flag three edges out.
  fault_sets_a: assert property (@(posedge clock) disable iff (rst)
    faultPin[3] |-> ##3 state_q.flag[3])
    else $error("Overload did not set its flag.");

  set_wins_a: assert property (@(posedge clock) disable iff (rst)
    state_q.sync2[0] |=> state_q.flag[0])
    else $error("Clear won over a fault in the same cycle.");

endmodule : dpo_overload_flags

/* design/dpo_pkg.sv */
package dpo_pkg;

  localparam int unsigned PortCount   = 4;
  localparam int unsigned PortWidth   = 8;
  localparam int unsigned DioWidth    = 32;
  localparam int unsigned ConvCount   = 8;
  localparam int unsigned AddrWidth   = 8;

  // Register byte offsets.
  localparam logic [7:0] OffDioOut    = 8'h00;
  localparam logic [7:0] OffDioIn     = 8'h04;
  localparam logic [7:0] OffDir       = 8'h08;
  localparam logic [7:0] OffOvlStat   = 8'h0C;
  localparam logic [7:0] OffIrqMask   = 8'h10;

  localparam logic [31:0] ResetZero   = 32'h0000_0000;
  localparam logic [3:0]  DirResetAll = 4'h0;

  localparam logic [1:0] RespOkay     = 2'h0;
  localparam logic [1:0] RespSlvErr   = 2'h2;

  typedef enum logic [1:0] {
    RdIdle = 2'b01,
    RdResp = 2'b10
  } dpo_rd_e;

  typedef enum logic [1:0] {
    WrIdle = 2'b01,
    WrResp = 2'b10
  } dpo_wr_e;

  typedef struct packed {
    logic        awvalid;
    logic [7:0]  awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [7:0]  araddr;
    logic        rready;
  } dpo_axi_req_s;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } dpo_axi_rsp_s;

  typedef struct packed {
    logic [7:0] detect;
    logic [7:0] flag;
  } dpo_ovl_s;

endpackage : dpo_pkg

/* verif/dpo_pin_model.sv */
`timescale 1ns/1ps
// External circuits on the digital connector. They drive every pin that the
// block leaves undriven, so an input pin never floats to an unknown level.
module dpo_pin_model (
  input  wire logic [31:0] dioOut,   // Block pin drive.
  input  wire logic [31:0] dioOe,    // Block output enables.
  input  wire logic [31:0] extDrive, // Level the circuits apply.
  output logic      [31:0] dioIn     // Resolved pin levels.
);
  // Each bit resolves on its own enable, so a per-bit direction slip in the
  // block shows up as a wrong pin level.
  assign dioIn = (dioOe & dioOut) | (~dioOe & extDrive);
endmodule : dpo_pin_model

/* verif/tb_dio_ports_overload_status.sv */
`timescale 1ns/1ps
module tb_dio_ports_overload_status;
  logic        clock, rst, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, irq;
  logic [7:0]  awaddr, araddr, ovlSense;
  logic [31:0] wdata, rdata, dioIn, dioOut, dioOe, extDrive;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  int          errors, checksDone;

  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  dpo_dio_top u_dut (
    .clock(clock), .rst(rst), .awvalid(awvalid), .awready(awready),
    .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata),
    .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .dioIn(dioIn), .dioOut(dioOut), .dioOe(dioOe),
    .ovlSense(ovlSense), .irq(irq)
  );

  dpo_pin_model u_pins (
    .dioOut(dioOut), .dioOe(dioOe), .extDrive(extDrive), .dioIn(dioIn)
  );

  task automatic close_out();
    if (errors == 0 && checksDone > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : close_out

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    checksDone++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Ready is sampled as it stood before the edge, so a release always
  // follows the edge that took the item.
  // Only the watchdog ends a wait. One idle edge at the end keeps a second
  // call from lowering and raising the same ready in one time step.
  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d,
                        output logic [1:0] resp);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge clock);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    resp = bresp;
    @(posedge clock);
  endtask : bus_wr

  task automatic bus_rd(input logic [7:0] a, output logic [31:0] d,
                        output logic [1:0] resp);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge clock);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    d = rdata;
    resp = rresp;
    @(posedge clock);
  endtask : bus_rd

  task automatic rd_chk(input string what, input logic [7:0] a,
                        input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0]  r;
    bus_rd(a, d, r);
    chk("rresp", {30'h0, dpo_pkg::RespOkay}, {30'h0, r});
    chk(what, exp, d);
  endtask : rd_chk

  task automatic test_reset();
    chk("dioOe", dpo_pkg::ResetZero, dioOe);
    rd_chk("dir", dpo_pkg::OffDir, 32'h0000_0000);
    rd_chk("ovlStat", dpo_pkg::OffOvlStat, 32'h0000_0000);
    chk("irq", 32'h0000_0000, {31'h0, irq});
  endtask : test_reset

  task automatic test_dir();
    logic [1:0] r;
    for (int p = 0; p < 4; p++) begin
      bus_wr(dpo_pkg::OffDir, 32'h0000_0001 << p, r);
      chk("bresp", {30'h0, dpo_pkg::RespOkay}, {30'h0, r});
      repeat (2) @(posedge clock);
      chk("dioOe", 32'h0000_00FF << (8 * p), dioOe);
    end
    bus_wr(dpo_pkg::OffDioOut, 32'hA5C3_0F96, r);
    bus_wr(dpo_pkg::OffDir, 32'h0000_000A, r);
    extDrive <= 32'h3C5A_E17B;
    repeat (4) @(posedge clock);
    chk("pins", 32'hA55A_0F7B, dioIn);
    rd_chk("dioIn", dpo_pkg::OffDioIn, 32'hA55A_0F7B);
    bus_wr(dpo_pkg::OffDioIn, 32'h0000_0000, r);
    wstrb <= 4'h2;
    bus_wr(dpo_pkg::OffDioOut, 32'hFFFF_FFFF, r);
    wstrb <= 4'hF;
    rd_chk("dioOut", dpo_pkg::OffDioOut, 32'hA5C3_FF96);
    bus_wr(dpo_pkg::OffDir, 32'h0000_0000, r);
  endtask : test_dir

  // Only the low four converters are unmasked, so irq must follow the mask.
  task automatic test_ovl();
    logic [1:0] r;
    bus_wr(dpo_pkg::OffIrqMask, 32'h0000_000F, r);
    rd_chk("mask", dpo_pkg::OffIrqMask, 32'h0000_000F);
    for (int n = 0; n < 8; n++) begin
      ovlSense <= 8'h01 << n;
      repeat (2) @(posedge clock);
      ovlSense <= 8'h00;
      repeat (4) @(posedge clock);
      rd_chk("ovlSet", dpo_pkg::OffOvlStat, 32'h1 << n);
      chk("irqSet", 32'(n < 4), {31'h0, irq});
      bus_wr(dpo_pkg::OffOvlStat, 32'h0000_0000, r);
      rd_chk("ovlHeld", dpo_pkg::OffOvlStat, 32'h1 << n);
      bus_wr(dpo_pkg::OffOvlStat, 32'h1 << n, r);
      repeat (2) @(posedge clock);
      rd_chk("ovlClr", dpo_pkg::OffOvlStat, 32'h0000_0000);
      chk("irqClr", 32'h0000_0000, {31'h0, irq});
    end
  endtask : test_ovl

  // A reset in mid-run must undo a direction and a flag already set.
  task automatic test_rereset();
    logic [1:0] r;
    bus_wr(dpo_pkg::OffDir, 32'h0000_000F, r);
    ovlSense <= 8'h40;
    repeat (2) @(posedge clock);
    ovlSense <= 8'h00;
    repeat (4) @(posedge clock);
    chk("dioOeSet", 32'hFFFF_FFFF, dioOe);
    rst <= 1'b1;
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    test_reset();
  endtask : test_rereset

  task automatic test_unmapped();
    logic [31:0] d;
    logic [1:0]  r;
    bus_rd(8'h14, d, r);
    chk("rdErr", {30'h0, dpo_pkg::RespSlvErr}, {30'h0, r});
    chk("rdZero", 32'h0000_0000, d);
    bus_wr(8'h14, 32'hFFFF_FFFF, r);
    chk("wrErr", {30'h0, dpo_pkg::RespSlvErr}, {30'h0, r});
  endtask : test_unmapped

  initial begin
    rst      = 1'b1;
    awvalid  = 1'b0;
    wvalid   = 1'b0;
    bready   = 1'b0;
    arvalid  = 1'b0;
    rready   = 1'b0;
    awaddr   = 8'h00;
    araddr   = 8'h00;
    wdata    = 32'h0000_0000;
    wstrb    = 4'hF;
    extDrive = 32'h0000_0000;
    ovlSense = 8'h00;
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    test_reset();
    test_dir();
    test_ovl();
    test_rereset();
    test_unmapped();
    close_out();
  end

  // The whole run needs well under a thousand cycles.
  initial begin
    repeat (20000) @(posedge clock);
    errors++;
    close_out();
  end
endmodule : tb_dio_ports_overload_status
